//--- verilog/odt_pkg.sv
package odt_pkg;

    // ------------------------------------------------------------
    // bus map
    // ------------------------------------------------------------
    localparam logic [7:0] ODT_OFS_CTRL   = 8'h00; // unit, source selects, reset
    localparam logic [7:0] ODT_OFS_ONPRE  = 8'h04; // on-delay preset constant
    localparam logic [7:0] ODT_OFS_OFFPRE = 8'h08; // off-delay preset constant
    localparam logic [7:0] ODT_OFS_STAT   = 8'h0c; // output, phase
    localparam logic [7:0] ODT_OFS_ONCNT  = 8'h10; // on-delay elapsed
    localparam logic [7:0] ODT_OFS_OFFCNT = 8'h14; // off-delay elapsed
    localparam logic [7:0] ODT_OFS_SLOT   = 8'h18; // base slot number
    localparam logic [7:0] ODT_OFS_DREG   = 8'h40; // data register window base

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          ODT_CTRL_UNIT_LSB = 0;  // 2 bits
    localparam int          ODT_CTRL_ONSRC    = 2;  // 1: indirect
    localparam int          ODT_CTRL_OFFSRC   = 3;
    localparam int          ODT_CTRL_SWRST    = 4;
    localparam int          ODT_CTRL_ONIDX    = 8;  // 4 bits
    localparam int          ODT_CTRL_OFFIDX   = 12; // 4 bits
    localparam logic [15:0] ODT_RST_ONPRE     = 16'h000a;
    localparam logic [15:0] ODT_RST_OFFPRE    = 16'h000a;
    localparam logic [15:0] ODT_RST_CTRL      = 16'h0000;
    localparam logic [7:0]  ODT_RST_SLOT      = 8'h00;
    localparam logic [7:0]  ODT_SLOT_MAX      = 8'hc6; // 198
    localparam logic [7:0]  ODT_SLOT_MAX_SML  = 8'h62; // 98

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    localparam int ODT_CLK_HZ     = 50_000_000;
    localparam int ODT_UNIT_MS    = 1;
    localparam int ODT_CYC_PER_MS = ODT_CLK_HZ / 1000 * ODT_UNIT_MS;

    typedef enum logic [1:0] {
        ODT_U_1S, ODT_U_100MS, ODT_U_10MS, ODT_U_1MS
    } odt_unit_t;

    typedef enum logic [1:0] {
        ODT_IDLE, ODT_ONDLY, ODT_HOLD, ODT_OFFDLY
    } odt_state_t;

    typedef struct packed {
        logic [15:0] onPre;
        logic [15:0] offPre;
        odt_unit_t   unit;
    } odt_cfg_t;

endpackage

//--- verilog/odt_tick_gen.sv
`timescale 1ns/1ns
module odt_tick_gen
    import odt_pkg::*;
#(
    parameter int MS_CYCLES = ODT_CYC_PER_MS
) (
    input  wire logic      mclk,
    input  wire logic      rst,
    input  wire odt_unit_t unit,
    output logic           tick
);
    initial begin
        if (MS_CYCLES < 1) $error("MS_CYCLES must be at least 1");
    end

    logic [31:0] msCnt_r;
    logic [9:0]  msDiv_r;
    logic        msTick;
    logic [9:0]  msLimit;

    assign msTick = (msCnt_r == 32'(MS_CYCLES - 1));

    // ------------------------------------------------------------
    // 1 ms prescaler
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            msCnt_r <= 32'h0;
        end else if (msTick) begin
            msCnt_r <= 32'h0;
        end else begin
            msCnt_r <= msCnt_r + 32'h1;
        end
    end

    // unit picks how many milliseconds per count
    always_comb begin
        case (unit)
            ODT_U_1S:    msLimit = 10'd999;
            ODT_U_100MS: msLimit = 10'd99;
            ODT_U_10MS:  msLimit = 10'd9;
            default:     msLimit = 10'd0;
        endcase
    end

    // a unit change keeps the divider count; a count past the new limit ticks at the next ms
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            msDiv_r <= 10'h0;
            tick    <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (msTick) begin
                if (msDiv_r >= msLimit) begin
                    msDiv_r <= 10'h0;
                    tick    <= 1'b1;
                end else begin
                    msDiv_r <= msDiv_r + 10'h1;
                end
            end
        end
    end
endmodule

//--- verilog/odt_apb_regs.sv
`timescale 1ns/1ns
module odt_apb_regs
    import odt_pkg::*;
#(
    parameter int NDREG = 16
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] statWord,
    input  wire logic [15:0] onCnt,
    input  wire logic [15:0] offCnt,
    output odt_cfg_t         cfg,
    output logic             swReset
);
    initial begin
        if (NDREG != 16) $error("NDREG must be 16");
    end

    logic [15:0] ctrl_r;
    logic [15:0] onPre_r;
    logic [15:0] offPre_r;
    logic [7:0]  slot_r;
    logic [15:0] dreg_r [NDREG];
    logic        access;
    logic        isDreg;
    logic [3:0]  dIdx;
    logic        hit;
    logic [31:0] rdVal;

    assign access = psel && penable;
    assign isDreg = (paddr >= ODT_OFS_DREG) && (paddr < ODT_OFS_DREG + 8'h40);
    assign dIdx   = paddr[5:2];

    // ------------------------------------------------------------
    // register writes; all storage is volatile flops
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_r   <= ODT_RST_CTRL;
            onPre_r  <= ODT_RST_ONPRE;
            offPre_r <= ODT_RST_OFFPRE;
            slot_r   <= ODT_RST_SLOT;
        end else if (access && pwrite) begin
            case (paddr)
                ODT_OFS_CTRL:   ctrl_r   <= pwdata[15:0];
                ODT_OFS_ONPRE:  onPre_r  <= pwdata[15:0];
                ODT_OFS_OFFPRE: offPre_r <= pwdata[15:0];
                // slot number clamps to the last usable pair base
                ODT_OFS_SLOT:   slot_r   <= (pwdata[7:0] > ODT_SLOT_MAX) ?
                                            ODT_SLOT_MAX : pwdata[7:0];
                default: ;
            endcase
        end
    end

    // data registers for indirect presets
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NDREG; i++) dreg_r[i] <= 16'h0;
        end else if (access && pwrite && isDreg && paddr[1:0] == 2'b00) begin
            dreg_r[dIdx] <= pwdata[15:0];
        end
    end

    // preset source: constant or data register by number
    assign cfg.onPre  = ctrl_r[ODT_CTRL_ONSRC]  ? dreg_r[ctrl_r[ODT_CTRL_ONIDX +: 4]]  : onPre_r;
    assign cfg.offPre = ctrl_r[ODT_CTRL_OFFSRC] ? dreg_r[ctrl_r[ODT_CTRL_OFFIDX +: 4]] : offPre_r;
    assign cfg.unit   = odt_unit_t'(ctrl_r[ODT_CTRL_UNIT_LSB +: 2]);
    assign swReset    = ctrl_r[ODT_CTRL_SWRST];

    always_comb begin
        hit   = 1'b1;
        rdVal = 32'h0;
        if (isDreg && paddr[1:0] == 2'b00) begin
            rdVal = {16'h0, dreg_r[dIdx]};
        end else begin
            case (paddr)
                ODT_OFS_CTRL:   rdVal = {16'h0, ctrl_r};
                ODT_OFS_ONPRE:  rdVal = {16'h0, onPre_r};
                ODT_OFS_OFFPRE: rdVal = {16'h0, offPre_r};
                ODT_OFS_STAT:   rdVal = statWord;
                ODT_OFS_ONCNT:  rdVal = {16'h0, onCnt};
                ODT_OFS_OFFCNT: rdVal = {16'h0, offCnt};
                ODT_OFS_SLOT:   rdVal = {24'h0, slot_r};
                default:        hit   = 1'b0;
            endcase
        end
    end

    // no wait state: ready in the first access cycle, unmapped gives pslverr
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata  <= (psel && !penable && !pwrite) ? rdVal : 32'h0;
        end
    end
endmodule

//--- verilog/on_off_delay_timer.sv
`timescale 1ns/1ns
module on_off_delay_timer
    import odt_pkg::*;
#(
    parameter int MS_CYCLES = ODT_CYC_PER_MS
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        execution_in,
    input  wire logic        timerReset,
    output logic             timerOut
);
    odt_cfg_t    cfg;
    logic        swReset;
    logic        tick;
    logic        clr;
    logic        execPrev_r;
    logic [15:0] onCnt_r;
    logic [15:0] offCnt_r;
    odt_state_t  state_r;
    logic [31:0] statWord;

    // ------------------------------------------------------------
    // register slave and time base
    // ------------------------------------------------------------
    odt_apb_regs u_regs (
        .mclk     (mclk),
        .rst      (rst),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .statWord (statWord),
        .onCnt    (onCnt_r),
        .offCnt   (offCnt_r),
        .cfg      (cfg),
        .swReset  (swReset)
    );

    odt_tick_gen #(.MS_CYCLES(MS_CYCLES)) u_tick (
        .mclk (mclk),
        .rst  (rst),
        .unit (cfg.unit),
        .tick (tick)
    );

    // bench ties timerReset low when unused; either source clears
    assign clr = timerReset || swReset;

    assign statWord = {28'h0, 2'(state_r), 1'b0, timerOut};

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            execPrev_r <= 1'b0;
        end else begin
            execPrev_r <= execution_in;
        end
    end

    // ------------------------------------------------------------
    // sequencing; presets compared live so changes act at once
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r  <= ODT_IDLE;
            onCnt_r  <= 16'h0;
            offCnt_r <= 16'h0;
            timerOut <= 1'b0;
        end else if (clr) begin
            state_r  <= ODT_IDLE; // reset beats everything
            onCnt_r  <= 16'h0;
            offCnt_r <= 16'h0;
            timerOut <= 1'b0;
        end else begin
            case (state_r)
                ODT_IDLE: begin
                    // only a rising edge arms, a held-high input does nothing
                    if (execution_in && !execPrev_r) begin
                        onCnt_r <= 16'h0;
                        state_r <= ODT_ONDLY;
                    end
                end
                ODT_ONDLY: begin
                    if (!execution_in) begin
                        state_r <= ODT_IDLE;
                    end else if (onCnt_r >= cfg.onPre) begin
                        timerOut <= 1'b1;
                        state_r  <= ODT_HOLD;
                    end else if (tick) begin
                        onCnt_r <= onCnt_r + 16'h1;
                    end
                end
                ODT_HOLD: begin
                    if (!execution_in) begin
                        offCnt_r <= 16'h0;
                        state_r  <= ODT_OFFDLY;
                    end
                end
                ODT_OFFDLY: begin
                    if (execution_in) begin
                        offCnt_r <= 16'h0;
                        state_r  <= ODT_HOLD;
                    end else if (offCnt_r >= cfg.offPre) begin
                        timerOut <= 1'b0;
                        onCnt_r  <= 16'h0;
                        state_r  <= ODT_IDLE;
                    end else if (tick) begin
                        offCnt_r <= offCnt_r + 16'h1;
                    end
                end
                default: state_r <= ODT_IDLE;
            endcase
        end
    end
endmodule

//--- tb/odt_ctrl_model.sv
`timescale 1ns/1ns
module odt_ctrl_model (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic wantExec,
    input  wire logic wantRst,
    output logic      execution_in,
    output logic      timerReset
);
    // ----------------------------------------
    // controller scan
    // ----------------------------------------
    // inputs move once per scan, just after the edge, never mid-cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            execution_in <= 1'b0;
            timerReset   <= 1'b0;
        end else begin
            execution_in <= wantExec;
            timerReset   <= wantRst;
        end
    end
endmodule

//--- tb/odt_monitor.sv
`timescale 1ns/1ns
module odt_monitor (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        execution_in,
    input wire logic        timerReset,
    input wire logic        timerOut
);
    // ----------------------------------------
    // bus and timer checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // zero wait states: answer in the first access cycle
    sequence setupSeq;
        psel && !penable ##1 psel && penable;
    endsequence
    ready_in_access_a: assert property (setupSeq |-> pready)
        else $error("pready missing in first access cycle");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_read_zero_a: assert property (pslverr |-> pready && (pwrite || prdata == 0))
        else $error("bad error response");
    upper_bits_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    no_early_on_a: assert property ($rose(execution_in) && !timerOut |=> !timerOut)
        else $error("output on at start of on-delay");
    on_needs_exec_a: assert property ($rose(timerOut) |-> $past(execution_in))
        else $error("output on without execution input");
    off_has_cause_a: assert property ($fell(timerOut) |-> !$past(execution_in) || $past(timerReset))
        else $error("output off without cause");
    hold_while_on_a: assert property (timerOut && execution_in && !timerReset |=> timerOut)
        else $error("output dropped while execution on");
    reset_forces_off_a: assert property (timerReset |=> !timerOut)
        else $error("timer reset did not clear output");
endmodule
bind on_off_delay_timer odt_monitor mon (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .execution_in(execution_in), .timerReset(timerReset),
    .timerOut(timerOut));

//--- tb/tb.sv
`timescale 1ns/1ns
module tb;
    import odt_pkg::*;
    localparam int MSC = 2; // short millisecond keeps the 1 s unit affordable
    logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, execution_in, timerReset, timerOut, e;
    logic        wantExec = 0, wantRst = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    int          errors = 0, samples_checked = 0, n;
    // ----------------------------------------
    // clock, design and controller
    // ----------------------------------------
    always #10 mclk = ~mclk;
    on_off_delay_timer #(.MS_CYCLES(MSC)) dut (.mclk(mclk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .execution_in(execution_in), .timerReset(timerReset), .timerOut(timerOut));
    odt_ctrl_model ctl (.mclk(mclk), .rst(rst), .wantExec(wantExec),
        .wantRst(wantRst), .execution_in(execution_in), .timerReset(timerReset));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic wrap_up;
        if (errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic rng(input string nm, input int lo, input int hi);
        chk(nm, 32'h1, 32'(n >= lo && n <= hi));
    endtask
    // one transfer; waits an edge first so back-to-back calls never clash
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errors++;
            wrap_up();
        end
    endtask
    task automatic ex(input logic v);
        @(posedge mclk);
        wantExec <= v;
    endtask
    task automatic wait_out(input logic v, input int lim);
        n = 0;
        while (timerOut !== v && n < lim) begin
            @(posedge mclk);
            n++;
        end
        if (timerOut !== v) begin
            errors++;
            wrap_up();
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        apb(ODT_OFS_ONPRE, 0, 0);
        chk("onPreReset", 32'(ODT_RST_ONPRE), q);
        apb(ODT_OFS_OFFPRE, 0, 0);
        chk("offPreReset", 32'(ODT_RST_OFFPRE), q);
        apb(8'h30, 0, 0);
        chk("unmappedErr", 32'h1, 32'(e));
        apb(ODT_OFS_SLOT, 1, 32'hff);
        apb(ODT_OFS_SLOT, 0, 0);
        chk("slotClamp", 32'(ODT_SLOT_MAX), q);
        apb(ODT_OFS_ONPRE, 1, 32'hffff);
        apb(ODT_OFS_ONPRE, 0, 0);
        chk("onPreMax", 32'hffff, q);
    endtask
    // every unit: delay lands within one tick of preset times period
    task automatic t_units;
        int per;
        for (int u = 0; u < 4; u++) begin
            per = MSC * (u == 0 ? 1000 : u == 1 ? 100 : u == 2 ? 10 : 1);
            apb(ODT_OFS_CTRL, 1, 32'(u));
            apb(ODT_OFS_ONPRE, 1, 32'h2);
            apb(ODT_OFS_OFFPRE, 1, 32'h3);
            ex(1'b1);
            wait_out(1'b1, 9 * per);
            rng("onDelay", per, 2 * per + 6);
            ex(1'b0);
            wait_out(1'b0, 9 * per);
            rng("offDelay", 2 * per, 3 * per + 6);
        end
    endtask
    task automatic t_retrig;
        apb(ODT_OFS_OFFPRE, 1, 32'h6);
        ex(1'b1);
        wait_out(1'b1, 50);
        ex(1'b0);
        repeat (6) @(posedge mclk);
        chk("outHeld", 32'h1, 32'(timerOut));
        ex(1'b1);
        // let the input reach the design and the clear land before reading
        repeat (2) @(posedge mclk);
        apb(ODT_OFS_OFFCNT, 0, 0);
        chk("offCntClr", 32'h0, q);
        ex(1'b0);
        wait_out(1'b0, 60);
        rng("offFull", 10, 18);
    endtask
    task automatic t_rst_pri;
        ex(1'b1);
        wait_out(1'b1, 50);
        wantRst <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("rstOff", 32'h0, 32'(timerOut));
        wantRst <= 1'b0;
        repeat (10) @(posedge mclk);
        chk("noRestart", 32'h0, 32'(timerOut));
        ex(1'b0);
    endtask
    task automatic t_preset;
        apb(ODT_OFS_ONPRE, 1, 32'd100);
        ex(1'b1);
        repeat (20) @(posedge mclk);
        chk("onNotYet", 32'h0, 32'(timerOut));
        apb(ODT_OFS_ONPRE, 1, 32'h3);
        wait_out(1'b1, 40);
        rng("onPreCut", 0, 4);
        apb(ODT_OFS_OFFPRE, 1, 32'd100);
        ex(1'b0);
        repeat (20) @(posedge mclk);
        chk("offNotYet", 32'h1, 32'(timerOut));
        apb(ODT_OFS_OFFPRE, 1, 32'h2);
        wait_out(1'b0, 40);
        rng("offPreCut", 0, 4);
    endtask
    // preset read from data register 2; constant preset left large
    task automatic t_indirect;
        apb(ODT_OFS_ONPRE, 1, 32'd100);
        apb(ODT_OFS_DREG + 8'h08, 1, 32'h4);
        apb(ODT_OFS_CTRL, 1, 32'h0207);
        ex(1'b1);
        wait_out(1'b1, 60);
        rng("indirectOn", 6, 14);
        ex(1'b0);
        wait_out(1'b0, 60);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_units();
        t_retrig();
        t_rst_pri();
        t_preset();
        t_indirect();
        wrap_up();
    end
endmodule
